//--- src/pitc_pkg.sv
`default_nettype none
package pitc_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int CLASS_W = 4;
    localparam int REG_W = 5;
    localparam int CNT_W = 4;

    // ----------------------------------------------------------------
    // Instruction classes seen by the issue controller
    // ----------------------------------------------------------------
    typedef enum logic [CLASS_W-1:0] {
        PITC_REG_XFER = 4'h0,
        PITC_LOAD_SYSREG_MEM_POSTINC = 4'h1,
        PITC_STORE_SYSREG_MEM_PREDEC = 4'h2,
        PITC_LOAD_CTRLREG_MEM_POSTINC = 4'h3,
        PITC_STORE_CTRLREG_MEM_PREDEC = 4'h4,
        PITC_CLEAR_OR_LOAD_ACCUM_GPR = 4'h5,
        PITC_LOAD_DSP_FROM_GPR = 4'h6,
        PITC_LOAD_ACCUM_MEM_POSTINC = 4'h7,
        PITC_MOVE_ACCUM_TO_GPR = 4'h8,
        PITC_STORE_ACCUM_MEM_PREDEC = 4'h9,
        PITC_EXCEPTION_RETURN = 4'hA,
        PITC_SOFTWARE_TRAP = 4'hB,
        PITC_SLEEP = 4'hC,
        PITC_BRANCH_COND = 4'hD,
        PITC_BRANCH_COND_DELAYED = 4'hE
    } pitc_class_t;

    // ----------------------------------------------------------------
    // Stage counts
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] STG_REG_XFER = 4'h3;
    localparam logic [CNT_W-1:0] STG_MEM_LOAD = 4'h5;
    localparam logic [CNT_W-1:0] STG_MEM_STORE = 4'h4;
    localparam logic [CNT_W-1:0] STG_ACC_LOAD = 4'h4;
    localparam logic [CNT_W-1:0] STG_ACC_TO_GPR = 4'h5;
    localparam logic [CNT_W-1:0] STG_EXC_RETURN = 4'h5;
    localparam logic [CNT_W-1:0] STG_TRAP = 4'h9;
    localparam logic [CNT_W-1:0] STG_SLEEP = 4'h3;
    localparam logic [CNT_W-1:0] STG_BRANCH = 4'h3;

    // ----------------------------------------------------------------
    // Minimum issue cycle counts
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] CYC_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CYC_LOAD_CTRL = 4'h3;
    localparam logic [CNT_W-1:0] CYC_STORE_CTRL = 4'h2;
    localparam logic [CNT_W-1:0] CYC_EXC_RETURN = 4'h4;
    localparam logic [CNT_W-1:0] CYC_TRAP = 4'h8;
    localparam logic [CNT_W-1:0] CYC_SLEEP = 4'h3;
    localparam logic [CNT_W-1:0] CYC_BRANCH_TAKEN = 4'h3;
    localparam logic [CNT_W-1:0] CYC_DBRANCH_TAKEN = 4'h2;

    // ----------------------------------------------------------------
    // Hazard timing
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] LOAD_USE_STALL = 4'h1;
    localparam int MA_DELAY = 2;
endpackage : pitc_pkg
`default_nettype wire

//--- src/pitc_issue_ctrl.sv
// Function
// - Return-address load from memory, post-increment: five stages, one cycle.
// - Return-address store, pre-decrement: four stages, one cycle, memory slot blocks fetch.
// - Control register load from memory: five stages, three cycles.
// - Control register store to memory: four stages, two cycles, blocks fetch.
// - Accumulator clear or load from general register: four stages, one cycle.
// - Accumulator transfers in or out wait while multiplier is busy.
// - DSP register load from general register: four stages, one cycle.
// - Accumulator load from memory: four stages, one cycle, multiplier and fetch contention.
// - Accumulator to general register: five stages, one cycle, waits on multiply.
// - Accumulator store to memory, pre-decrement: four stages, one cycle.
// - Next instruction reading a just-loaded register gets one stall cycle inserted.
// - Sleep takes three stages and three cycles, then core halts.
// - Conditional branch not taken completes in one cycle.
// - Register-to-register transfer finishes after three stages via the ALU.
`default_nettype none
module pitc_issue_ctrl
    import pitc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [CLASS_W-1:0] instr_class_i,
    input wire logic [REG_W-1:0] instr_dest_i,
    input wire logic [REG_W-1:0] instr_src_a_i,
    input wire logic [REG_W-1:0] instr_src_b_i,
    input wire logic instr_uses_src_i,
    input wire logic branch_taken_i,
    input wire logic mult_busy_i,
    input wire logic fetch_req_i,
    input wire logic wake_i,
    output logic instr_ready_o,
    output logic fetch_grant_o,
    output logic mem_slot_o,
    output logic stall_o,
    output logic halted_o,
    output logic [CNT_W-1:0] issued_stages_o,
    output logic [CNT_W-1:0] issued_cycles_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_BUSY = 3'h2,
        ST_HALT = 3'h4
    } pitc_state_t;

    pitc_state_t state_q;
    pitc_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [MA_DELAY-1:0] ma_pipe_q;
    logic ld_valid_q;
    logic [REG_W-1:0] ld_dest_q;
    logic sleeping_q;
    logic wake_meta_q;
    logic wake_sync_q;
    logic [CNT_W-1:0] stg_q;
    logic [CNT_W-1:0] cyc_q;
    logic [CNT_W-1:0] base_stages;
    logic [CNT_W-1:0] base_cycles;
    logic is_mem;
    logic is_load;
    logic is_accum;
    logic hazard;
    logic ma_active;
    logic issue;

    // ----------------------------------------------------------------
    // Class decode
    // ----------------------------------------------------------------
    // Stages, minimum cycles and resource use per class
    always_comb begin
        base_stages = STG_REG_XFER;
        base_cycles = CYC_ONE;
        is_mem = 1'b0;
        is_load = 1'b0;
        is_accum = 1'b0;
        case (instr_class_i)
            PITC_REG_XFER: begin
                base_stages = STG_REG_XFER;
            end
            PITC_LOAD_SYSREG_MEM_POSTINC: begin
                base_stages = STG_MEM_LOAD;
                is_mem = 1'b1;
                is_load = 1'b1;
            end
            PITC_STORE_SYSREG_MEM_PREDEC: begin
                base_stages = STG_MEM_STORE;
                is_mem = 1'b1;
            end
            PITC_LOAD_CTRLREG_MEM_POSTINC: begin
                base_stages = STG_MEM_LOAD;
                base_cycles = CYC_LOAD_CTRL;
                is_mem = 1'b1;
                is_load = 1'b1;
            end
            PITC_STORE_CTRLREG_MEM_PREDEC: begin
                base_stages = STG_MEM_STORE;
                base_cycles = CYC_STORE_CTRL;
                is_mem = 1'b1;
            end
            PITC_CLEAR_OR_LOAD_ACCUM_GPR: begin
                base_stages = STG_ACC_LOAD;
                is_accum = 1'b1;
                is_mem = 1'b1;
            end
            PITC_LOAD_DSP_FROM_GPR: begin
                base_stages = STG_ACC_LOAD;
            end
            PITC_LOAD_ACCUM_MEM_POSTINC: begin
                base_stages = STG_ACC_LOAD;
                is_accum = 1'b1;
                is_mem = 1'b1;
            end
            PITC_MOVE_ACCUM_TO_GPR: begin
                base_stages = STG_ACC_TO_GPR;
                is_accum = 1'b1;
                is_load = 1'b1;
            end
            PITC_STORE_ACCUM_MEM_PREDEC: begin
                base_stages = STG_MEM_STORE;
                is_accum = 1'b1;
                is_mem = 1'b1;
            end
            PITC_EXCEPTION_RETURN: begin
                base_stages = STG_EXC_RETURN;
                base_cycles = CYC_EXC_RETURN;
            end
            PITC_SOFTWARE_TRAP: begin
                base_stages = STG_TRAP;
                base_cycles = CYC_TRAP;
            end
            PITC_SLEEP: begin
                base_stages = STG_SLEEP;
                base_cycles = CYC_SLEEP;
            end
            PITC_BRANCH_COND: begin
                base_stages = STG_BRANCH;
                base_cycles = branch_taken_i ? CYC_BRANCH_TAKEN : CYC_ONE;
            end
            PITC_BRANCH_COND_DELAYED: begin
                base_stages = STG_BRANCH;
                base_cycles = branch_taken_i ? CYC_DBRANCH_TAKEN : CYC_ONE;
            end
            default: begin
                base_stages = STG_REG_XFER;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Issue decision
    // ----------------------------------------------------------------
    // Memory slot owns the bus this cycle
    assign ma_active = ma_pipe_q[MA_DELAY-1];

    assign hazard = ld_valid_q && instr_uses_src_i &&
                    ((instr_src_a_i == ld_dest_q) || (instr_src_b_i == ld_dest_q));

    assign instr_ready_o = (state_q == ST_RUN) && !ma_active && !(is_accum && mult_busy_i);
    assign issue = instr_ready_o && instr_valid_i;

    // Fetch loses to the memory slot
    assign fetch_grant_o = fetch_req_i && !ma_active;
    assign mem_slot_o = ma_active;

    // Stall whenever a valid instruction cannot go, except while halted
    assign stall_o = instr_valid_i && !instr_ready_o && (state_q != ST_HALT);
    assign halted_o = (state_q == ST_HALT);

    // ----------------------------------------------------------------
    // Wake synchroniser
    // ----------------------------------------------------------------
    // Two flops for the external wake level
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wake_meta_q <= 1'b0;
            wake_sync_q <= 1'b0;
        end else begin
            wake_meta_q <= wake_i;
            wake_sync_q <= wake_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Issue sequencer
    // ----------------------------------------------------------------
    // Next state and busy count
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_RUN: begin
                if (issue) begin
                    // Hazard stall added to minimum count
                    cnt_d = hazard ? base_cycles + LOAD_USE_STALL : base_cycles;
                    if (cnt_d > CYC_ONE) begin
                        state_d = ST_BUSY;
                        cnt_d = cnt_d - CYC_ONE;
                    end else if (instr_class_i == PITC_SLEEP) begin
                        state_d = ST_HALT;
                    end
                end
            end
            ST_BUSY: begin
                cnt_d = cnt_q - CYC_ONE;
                if (cnt_q == CYC_ONE) begin
                    // Halt once sleep has run its cycles
                    state_d = sleeping_q ? ST_HALT : ST_RUN;
                end
            end
            ST_HALT: begin
                if (wake_sync_q) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
                cnt_d = '0;
            end
        endcase
    end

    // State and counter registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= ST_RUN;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Remember a sleep in progress
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sleeping_q <= 1'b0;
        end else if (issue) begin
            sleeping_q <= (instr_class_i == PITC_SLEEP);
        end else if (state_q == ST_HALT) begin
            sleeping_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Memory slot tracking
    // ----------------------------------------------------------------
    // Memory slot shifts toward its stage
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ma_pipe_q <= '0;
        end else begin
            ma_pipe_q <= {ma_pipe_q[MA_DELAY-2:0], issue && is_mem};
        end
    end

    // ----------------------------------------------------------------
    // Load destination tracking
    // ----------------------------------------------------------------
    // Hold destination of the last issued instruction and whether it was a load
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ld_valid_q <= 1'b0;
            ld_dest_q <= '0;
        end else if (issue) begin
            ld_valid_q <= is_load;
            ld_dest_q <= instr_dest_i;
        end
    end

    // ----------------------------------------------------------------
    // Issue report
    // ----------------------------------------------------------------
    // Stages and cycles of the last issued instruction
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            stg_q <= '0;
            cyc_q <= '0;
        end else if (issue) begin
            stg_q <= base_stages;
            cyc_q <= hazard ? base_cycles + LOAD_USE_STALL : base_cycles;
        end
    end

    assign issued_stages_o = stg_q;
    assign issued_cycles_o = cyc_q;

endmodule : pitc_issue_ctrl
`default_nettype wire

//--- tb/pitc_issue_monitor.sv
`default_nettype none
module pitc_issue_monitor
    import pitc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [CLASS_W-1:0] instr_class_i,
    input wire logic instr_uses_src_i,
    input wire logic branch_taken_i,
    input wire logic mult_busy_i,
    input wire logic fetch_req_i,
    input wire logic wake_i,
    input wire logic instr_ready_o,
    input wire logic fetch_grant_o,
    input wire logic mem_slot_o,
    input wire logic halted_o,
    input wire logic [CNT_W-1:0] issued_stages_o,
    input wire logic [CNT_W-1:0] issued_cycles_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    // Issue event and class groups
    logic issue;
    logic mem_cls;
    logic acc_cls;
    assign issue = instr_valid_i && instr_ready_o;
    assign mem_cls = instr_class_i inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9};
    assign acc_cls = instr_class_i inside {4'h5, 4'h7, 4'h8, 4'h9};

    // Sleep drains two cycles, then the core stops
    sequence s_sleep_drain;
        !instr_ready_o [*2];
    endsequence
    sequence s_core_halted;
        halted_o && !instr_ready_o;
    endsequence
    // Control store waits a cycle, then owns the bus
    sequence s_store_wait;
        issued_stages_o == 4'h4 && !instr_ready_o;
    endsequence
    sequence s_store_slot;
        mem_slot_o && !instr_ready_o;
    endsequence

    chk_load_stages: assert property (issue && instr_class_i == 4'h1 |=> issued_stages_o == 4'h5)
        else $error("return address load stage count wrong");
    chk_ctrl_load: assert property (issue && instr_class_i == 4'h3 |=>
        (issued_stages_o == 4'h5 && !instr_ready_o) [*2])
        else $error("control load not held three cycles");
    chk_ctrl_store: assert property (issue && instr_class_i == 4'h4 |=> s_store_wait ##1 s_store_slot)
        else $error("control store timing wrong");
    chk_slot_timing: assert property (issue && mem_cls |-> ##2 mem_slot_o)
        else $error("memory slot missing two cycles after issue");
    chk_fetch_yield: assert property (mem_slot_o |-> !fetch_grant_o)
        else $error("fetch granted during memory slot");
    chk_fetch_grant: assert property (fetch_req_i && !mem_slot_o |-> fetch_grant_o)
        else $error("free fetch not granted");
    chk_accum_lock: assert property (instr_valid_i && acc_cls && mult_busy_i |-> !instr_ready_o)
        else $error("accumulator transfer taken while multiplier busy");
    chk_trap_wait: assert property (issue && instr_class_i == 4'hB |=>
        (issued_stages_o == 4'h9 && !instr_ready_o) [*7])
        else $error("software trap timing wrong");
    chk_sleep_halt: assert property (issue && instr_class_i == 4'hC && !wake_i |=>
        s_sleep_drain ##1 s_core_halted)
        else $error("sleep did not halt after three cycles");
    chk_branch_skip: assert property (issue && instr_class_i inside {4'hD, 4'hE} && !branch_taken_i
        && !instr_uses_src_i |=> issued_cycles_o == 4'h1)
        else $error("untaken branch not one cycle");
endmodule : pitc_issue_monitor

bind pitc_issue_ctrl pitc_issue_monitor pitc_issue_monitor_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_class_i(instr_class_i),
    .instr_uses_src_i(instr_uses_src_i), .branch_taken_i(branch_taken_i), .mult_busy_i(mult_busy_i),
    .fetch_req_i(fetch_req_i), .wake_i(wake_i), .instr_ready_o(instr_ready_o), .fetch_grant_o(fetch_grant_o),
    .mem_slot_o(mem_slot_o), .halted_o(halted_o), .issued_stages_o(issued_stages_o),
    .issued_cycles_o(issued_cycles_o)
);
`default_nettype wire

//--- tb/pitc_fetch_model.sv
`default_nettype none
module pitc_fetch_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic fetch_grant_i,
    output logic fetch_req_o,
    output logic [3:0] max_wait_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            fetch_req_o <= 1'h0;
            wait_q <= 4'h0;
            max_wait_o <= 4'h0;
        end else if (fetch_req_o && !fetch_grant_i) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q + 4'h1 > max_wait_o) max_wait_o <= wait_q + 4'h1;
        end else begin
            wait_q <= 4'h0;
            fetch_req_o <= ($urandom % 4) != 0; // Prompt or slow requester
        end
    end
endmodule : pitc_fetch_model
`default_nettype wire

//--- tb/pitc_issue_ctrl_bench.sv
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module pitc_issue_ctrl_bench
    import pitc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic instr_valid_i = 1'h0;
    logic [CLASS_W-1:0] instr_class_i = 4'h0;
    logic [REG_W-1:0] dest = 5'h0;
    logic [REG_W-1:0] src_a = 5'h0;
    logic [REG_W-1:0] src_b = 5'h0;
    logic uses_src = 1'h0;
    logic taken = 1'h0;
    logic mult_busy = 1'h0;
    logic wake = 1'h0;
    logic fetch_req;
    logic ready, grant, slot, stall, halted;
    logic [CNT_W-1:0] stages, cycles;
    logic [3:0] max_wait;
    int err_total = 0;
    int n_tests = 0;
    int last_ld = 0;
    int last_dest = 0;
    int slot_seen = 0;

    always #20 clock_i = ~clock_i;

    // Memory slot cycles seen by the bench
    always @(negedge clock_i) begin
        if (slot === 1'h1) slot_seen++;
    end

    pitc_issue_ctrl pitc_issue_ctrl_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
        .instr_class_i(instr_class_i), .instr_dest_i(dest), .instr_src_a_i(src_a), .instr_src_b_i(src_b),
        .instr_uses_src_i(uses_src), .branch_taken_i(taken), .mult_busy_i(mult_busy), .fetch_req_i(fetch_req),
        .wake_i(wake), .instr_ready_o(ready), .fetch_grant_o(grant), .mem_slot_o(slot), .stall_o(stall),
        .halted_o(halted), .issued_stages_o(stages), .issued_cycles_o(cycles));
    pitc_fetch_model pitc_fetch_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .fetch_grant_i(grant),
        .fetch_req_o(fetch_req), .max_wait_o(max_wait));

    // Reference stage and cycle tables
    function automatic int exp_stages(int c);
        case (c)
            1, 3, 8, 10: return 5;
            2, 4, 5, 6, 7, 9: return 4;
            11: return 9;
            default: return 3;
        endcase
    endfunction : exp_stages
    function automatic int exp_cycles(int c, bit tk);
        case (c)
            3: return 3;
            4: return 2;
            10: return 4;
            11: return 8;
            12: return 3;
            13: return tk ? 3 : 1;
            14: return tk ? 2 : 1;
            default: return 1;
        endcase
    endfunction : exp_cycles

    // Offer one instruction, check issue report and busy span
    task automatic issue(int c, int d, int sa, int sb, bit u, bit tk, bit mb);
        int cyc;
        int lows;
        int e;
        int s0;
        bit mem;
        bit acc;
        s0 = slot_seen;
        mem = c inside {1, 2, 3, 4, 5, 7, 9};
        acc = c inside {5, 7, 8, 9};
        cyc = exp_cycles(c, tk);
        if (last_ld != 0 && u && (sa == last_dest || sb == last_dest)) cyc++;
        @(posedge clock_i);
        instr_valid_i <= 1'h1;
        instr_class_i <= 4'(c);
        dest <= 5'(d);
        src_a <= 5'(sa);
        src_b <= 5'(sb);
        uses_src <= u;
        taken <= tk;
        mult_busy <= mb;
        @(negedge clock_i);
        `CHK("stall", acc && mb, stall)
        if (acc && mb) begin
            repeat (2) @(posedge clock_i);
            mult_busy <= 1'h0;
        end
        lows = 0;
        while (ready !== 1'h1 && lows < 50) begin
            @(negedge clock_i);
            lows++;
        end
        `CHK("ready", 1'h1, ready)
        @(posedge clock_i);
        instr_valid_i <= 1'h0;
        mult_busy <= 1'h0;
        last_ld = c inside {1, 3, 8};
        last_dest = d;
        @(negedge clock_i);
        `CHK("stages", 4'(exp_stages(c)), stages)
        `CHK("cycles", 4'(cyc), cycles)
        if (c != 12) begin
            lows = 0;
            while (ready !== 1'h1 && lows < 20) begin
                @(negedge clock_i);
                lows++;
            end
            e = cyc - 1;
            if (mem && e == 1) e = 2;
            `CHK("busy", e, lows)
            repeat (3) @(negedge clock_i);
            `CHK("slot", mem, slot_seen - s0)
        end
    endtask : issue

    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clock_i);
        err_total++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        void'($urandom(78701));
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'h1;
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 15; c++) begin
                if (c != 12) begin
                    issue(c, $urandom % 32, $urandom % 32, $urandom % 32, $urandom % 2, $urandom % 2, $urandom % 2);
                end
            end
        end
        issue(1, 5, 0, 0, 0, 0, 0);
        issue(0, 6, 5, 9, 1, 0, 0);
        issue(3, 7, 1, 2, 0, 0, 0);
        issue(13, 2, 4, 7, 1, 0, 0);
        issue(8, 9, 0, 0, 0, 0, 1);
        issue(0, 1, 2, 9, 1, 0, 0);
        issue(12, 0, 0, 0, 0, 0, 0);
        repeat (3) @(negedge clock_i);
        `CHK("halted", 1'h1, halted)
        `CHK("ready_halt", 1'h0, ready)
        @(posedge clock_i);
        wake <= 1'h1;
        repeat (8) @(negedge clock_i);
        `CHK("woken", 1'h0, halted)
        @(posedge clock_i);
        wake <= 1'h0;
        last_ld = 0;
        issue(10, 3, 0, 0, 0, 0, 0);
        `CHK("fetch_wait", 1'h1, max_wait <= 4'h1)
        report_and_stop();
    end
endmodule : pitc_issue_ctrl_bench
`default_nettype wire
